/* File: hdl/dic_filt.sv */
// noise filter for one input: the output follows only a level that held still
// assumes the raw input is already synchronous to aclk
`timescale 1ns/1ps
module dic_filt
  import dic_pkg::*;
#(
  parameter int MS_CYCLES = DIC_MS_CYC,
  parameter int IW = 16
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw,
  input wire logic [IW-1:0] interval,
  output logic filt_r
);
  localparam int CW = $clog2(MS_CYCLES + 1);
  logic [CW-1:0] cyc_r;
  logic [IW-1:0] ms_r;

  // ==========================================================
  // stability timer
  // any return to the old level restarts the whole interval
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_r <= 1'b0;
      cyc_r <= '0;
      ms_r <= '0;
    end
    else if (interval == '0 || raw == filt_r)
    begin
      filt_r <= raw; // R11
      cyc_r <= '0;
      ms_r <= '0;
    end
    else if (cyc_r == CW'(MS_CYCLES - 1))
    begin
      cyc_r <= '0;
      if (ms_r + 1'b1 >= interval)
      begin
        filt_r <= raw; // R15
        ms_r <= '0;
      end
      else
        ms_r <= ms_r + 1'b1;
    end
    else
      cyc_r <= cyc_r + 1'b1;
  end

  // ==========================================================
  // checks
  a_filt_bypass: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    interval == '0 |=> filt_r == $past(raw))
    else $error("filter not bypassed at zero interval");
  a_filt_early: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    (interval > 1 && ms_r == '0) |=> filt_r == $past(filt_r))
    else $error("filter changed before its interval");
endmodule

/* File: hdl/dic_top.sv */
// digital input conditioning: filters, counters, frequency, latches, direction
// assumes an AXI4-Lite master, one clock, field inputs already synchronous
`timescale 1ns/1ps
// How it works
// R1 - each channel counter has a preset that software sets; clear loads it
// R2 - frequency measurement is enabled per channel
// R3 - normal scan: result every 1000 ms, 1 Hz to 3.5 kHz, 1 Hz steps
// R4 - fast scan: result every 100 ms, 100 Hz to 3.5 kHz, 10 Hz steps
// R5 - single pulse: frequency from each period, 0.01 Hz steps
// R6 - windowed modes count pulses within the window
// R7 - moving average over 1, 2, 4 or 8 samples
// R8 - one global latch enable covers every channel
// R9 - writing one to clear-high clears all high latches; zero does nothing
// R10 - writing one to clear-low clears all low latches; zero does nothing
// R11 - noise filter interval in milliseconds; zero bypasses it
// R12 - direction bit one makes a channel an input, zero an output
// R13 - pulse counting is enabled per channel
// R14 - a command clears the channel counters
// R15 - filtered level changes only after the raw level held for the interval
// R16 - latched bits stay set until their clear command
module dic_top
  import dic_pkg::*;
#(
  parameter int NCH = 4,
  parameter int MS_CYCLES = DIC_MS_CYC,
  parameter int FW = 16
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] din,
  output logic [NCH-1:0] dio_dir_r,
  output logic irq_r
);
  localparam int SW = 2 * NCH + 1;
  localparam int MCW = $clog2(MS_CYCLES + 1);

  // ==========================================================
  // state
  logic aw_full_r, w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go, wr_ok, rd_ok;
  logic [31:0] rd_data;
  dic_ctrl_t ctrl_r;
  logic [NCH-1:0] cnt_en_r, freq_en_r, lat_hi_r, lat_lo_r, filt, filt_q_r, rise, fall;
  logic [FW-1:0] filt_ms_r;
  logic [SW-1:0] stat_r, mask_r, stat_set;
  logic [31:0] preset_r [NCH];
  logic [31:0] cnt_r [NCH];
  logic [31:0] freq_r [NCH];
  logic clr_hi_p, clr_lo_p, cnt_clr_p, ctrl_wr;
  logic [MCW-1:0] ms_cyc_r;
  logic [7:0] us_cyc_r;
  logic [9:0] win_ms_r;
  logic ms_tick, us_tick, win_done;
  logic [NCH-1:0] samp_vld;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = nw[8*b +: 8];
    return res;
  endfunction

  // ==========================================================
  // axi write channel: address and data taken in either order
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_r <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_full_r <= 1'b0;
    else if (!aw_full_r)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_r <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_r <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_go)
      w_full_r <= 1'b0;
    else if (!w_full_r)
      s_axi_wready <= 1'b1;
  end

  // write address decode; read-only offsets also answer okay
  always_comb
  begin
    wr_ok = awaddr_r inside {DIC_CTRL_OFS, DIC_CNT_EN_OFS, DIC_FREQ_EN_OFS, DIC_FILT_OFS,
      DIC_DIR_OFS, DIC_INPUT_OFS, DIC_LAT_HI_OFS, DIC_LAT_LO_OFS, DIC_STAT_OFS, DIC_MASK_OFS};
    for (int i = 0; i < NCH; i++)
      if (awaddr_r == 8'(DIC_PRESET_BASE + 4 * i) || awaddr_r == 8'(DIC_COUNT_BASE + 4 * i)
          || awaddr_r == 8'(DIC_FREQ_BASE + 4 * i))
        wr_ok = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DIC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? DIC_RESP_OKAY : DIC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // axi read channel
  always_comb
  begin
    rd_ok = 1'b1;
    rd_data = '0;
    unique case (s_axi_araddr)
      DIC_CTRL_OFS: rd_data = 32'({ctrl_r.avg, 2'b00, ctrl_r.scan, 3'b000, ctrl_r.latch_en});
      DIC_CNT_EN_OFS: rd_data = 32'(cnt_en_r);
      DIC_FREQ_EN_OFS: rd_data = 32'(freq_en_r);
      DIC_FILT_OFS: rd_data = 32'(filt_ms_r);
      DIC_DIR_OFS: rd_data = 32'(dio_dir_r);
      DIC_INPUT_OFS: rd_data = 32'(filt);
      DIC_LAT_HI_OFS: rd_data = 32'(lat_hi_r);
      DIC_LAT_LO_OFS: rd_data = 32'(lat_lo_r);
      DIC_STAT_OFS: rd_data = 32'(stat_r);
      DIC_MASK_OFS: rd_data = 32'(mask_r);
      default: rd_ok = 1'b0;
    endcase
    for (int i = 0; i < NCH; i++)
    begin
      if (s_axi_araddr == 8'(DIC_PRESET_BASE + 4 * i))
      begin
        rd_data = preset_r[i];
        rd_ok = 1'b1;
      end
      if (s_axi_araddr == 8'(DIC_COUNT_BASE + 4 * i))
      begin
        rd_data = cnt_r[i];
        rd_ok = 1'b1;
      end
      if (s_axi_araddr == 8'(DIC_FREQ_BASE + 4 * i))
      begin
        rd_data = freq_r[i];
        rd_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= DIC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? DIC_RESP_OKAY : DIC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ==========================================================
  // configuration registers and one-shot commands
  assign ctrl_wr = wr_go && awaddr_r == DIC_CTRL_OFS && wstrb_r[0];
  assign clr_hi_p = ctrl_wr && wdata_r[DIC_CLR_HI_BIT]; // R9
  assign clr_lo_p = ctrl_wr && wdata_r[DIC_CLR_LO_BIT]; // R10
  assign cnt_clr_p = ctrl_wr && wdata_r[DIC_CNT_CLR_BIT]; // R14
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= '{avg: DIC_AVG_1, scan: DIC_SCAN_NORM, latch_en: 1'b0};
      cnt_en_r <= '0;
      freq_en_r <= '0;
      filt_ms_r <= '0;
      dio_dir_r <= '1;
      mask_r <= '0;
    end
    else if (wr_go)
    begin
      if (ctrl_wr)
      begin
        ctrl_r.latch_en <= wdata_r[DIC_LATCH_BIT]; // R8
        ctrl_r.scan <= wdata_r[DIC_SCAN_LSB +: 2];
      end
      if (awaddr_r == DIC_CTRL_OFS && wstrb_r[1])
        ctrl_r.avg <= wdata_r[DIC_AVG_LSB +: 4];
      if (awaddr_r == DIC_CNT_EN_OFS)
        cnt_en_r <= NCH'(wmerge(32'(cnt_en_r), wdata_r, wstrb_r)); // R13
      if (awaddr_r == DIC_FREQ_EN_OFS)
        freq_en_r <= NCH'(wmerge(32'(freq_en_r), wdata_r, wstrb_r)); // R2
      if (awaddr_r == DIC_FILT_OFS)
        filt_ms_r <= FW'(wmerge(32'(filt_ms_r), wdata_r, wstrb_r)); // R11
      if (awaddr_r == DIC_DIR_OFS)
        dio_dir_r <= NCH'(wmerge(32'(dio_dir_r), wdata_r, wstrb_r)); // R12
      if (awaddr_r == DIC_MASK_OFS)
        mask_r <= SW'(wmerge(32'(mask_r), wdata_r, wstrb_r));
    end
  end

  // ==========================================================
  // time base: microsecond and millisecond ticks, scan window
  assign us_tick = us_cyc_r == 8'(DIC_US_CYC - 1);
  assign ms_tick = ms_cyc_r == MCW'(MS_CYCLES - 1);
  // at or past the end: a switch to the short window mid-count must not wait for a wrap
  assign win_done = ms_tick && win_ms_r >= ((ctrl_r.scan == DIC_SCAN_FAST) ?
    10'(DIC_FAST_WIN_MS - 1) : 10'(DIC_NORM_WIN_MS - 1)); // R3 R4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      us_cyc_r <= '0;
      ms_cyc_r <= '0;
      win_ms_r <= '0;
    end
    else
    begin
      us_cyc_r <= us_tick ? '0 : us_cyc_r + 1'b1;
      ms_cyc_r <= ms_tick ? '0 : ms_cyc_r + 1'b1;
      if (win_done)
        win_ms_r <= '0;
      else if (ms_tick)
        win_ms_r <= win_ms_r + 1'b1;
    end
  end

  // ==========================================================
  // latches on filtered edges; a new edge beats a clear in the same cycle
  assign rise = filt & ~filt_q_r;
  assign fall = ~filt & filt_q_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_q_r <= '0;
      lat_hi_r <= '0;
      lat_lo_r <= '0;
    end
    else
    begin
      filt_q_r <= filt;
      lat_hi_r <= (lat_hi_r & ~{NCH{clr_hi_p}}) | (rise & {NCH{ctrl_r.latch_en}}); // R8 R9 R16
      lat_lo_r <= (lat_lo_r & ~{NCH{clr_lo_p}}) | (fall & {NCH{ctrl_r.latch_en}}); // R8 R10 R16
    end
  end

  // ==========================================================
  // interrupt: sticky status, write one to clear, set wins
  assign stat_set = {win_done && ctrl_r.scan != DIC_SCAN_SINGLE && |freq_en_r,
                     fall & {NCH{ctrl_r.latch_en}}, rise & {NCH{ctrl_r.latch_en}}};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_go && awaddr_r == DIC_STAT_OFS)
        stat_r <= (stat_r & ~SW'(wmerge('0, wdata_r, wstrb_r))) | stat_set;
      else
        stat_r <= stat_r | stat_set;
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ==========================================================
  // per channel: filter, counter, frequency and averaging
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [15:0] edges_r;
    logic [DIC_DIV_W-1:0] per_r, den_r, quo_r;
    logic [DIC_DIV_W:0] rem_r, rem_sub;
    logic [4:0] step_r;
    logic have_r, tmo, div_done;
    dic_div_st_t div_st_r;
    logic [31:0] samp, samp_r, avg_val;
    logic [31:0] hist_r [8];
    logic [34:0] sum;

    // output channels are held low so they record nothing
    dic_filt #(.MS_CYCLES(MS_CYCLES), .IW(FW)) u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw(din[i] & dio_dir_r[i]), // R12
      .interval(filt_ms_r),
      .filt_r(filt[i])
    );

    // pulse counter; clear loads the preset and wins over a pulse
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        preset_r[i] <= '0;
        cnt_r[i] <= '0;
      end
      else
      begin
        if (wr_go && awaddr_r == 8'(DIC_PRESET_BASE + 4 * i))
          preset_r[i] <= wmerge(preset_r[i], wdata_r, wstrb_r); // R1
        if (cnt_clr_p)
          cnt_r[i] <= preset_r[i]; // R1 R14
        else if (cnt_en_r[i] && rise[i])
          cnt_r[i] <= cnt_r[i] + 1'b1; // R13
      end
    end

    // pulses inside the scan window, saturating
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        edges_r <= '0;
      else if (win_done)
        edges_r <= 16'(rise[i]); // R6
      else if (rise[i] && edges_r != '1)
        edges_r <= edges_r + 1'b1;
    end

    // single pulse: period in microseconds, restoring divide of 1e8 by it
    assign tmo = us_tick && per_r == DIC_DIV_W'(DIC_CENTI_NUM - 1);
    assign rem_sub = {rem_r[DIC_DIV_W-1:0], quo_r[DIC_DIV_W-1]} - {1'b0, den_r};
    assign div_done = div_st_r == DIC_DIV_RUN && step_r == 5'(DIC_DIV_W - 1);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        per_r <= '0;
        have_r <= 1'b0;
        div_st_r <= DIC_DIV_IDLE;
        den_r <= '0;
        quo_r <= '0;
        rem_r <= '0;
        step_r <= '0;
      end
      else
      begin
        if (rise[i])
        begin
          per_r <= DIC_DIV_W'(us_tick); // a tick on the edge cycle opens the new period
          have_r <= 1'b1;
          if (have_r && per_r != '0 && div_st_r == DIC_DIV_IDLE)
          begin
            div_st_r <= DIC_DIV_RUN; // R5
            den_r <= per_r;
            quo_r <= DIC_DIV_W'(DIC_CENTI_NUM);
            rem_r <= '0;
            step_r <= '0;
          end
        end
        else if (tmo)
          have_r <= 1'b0;
        else if (us_tick && have_r)
          per_r <= per_r + 1'b1;
        if (div_st_r == DIC_DIV_RUN)
        begin
          unique case (rem_sub[DIC_DIV_W])
            1'b0: rem_r <= rem_sub;
            1'b1: rem_r <= {rem_r[DIC_DIV_W-1:0], quo_r[DIC_DIV_W-1]};
          endcase
          quo_r <= {quo_r[DIC_DIV_W-2:0], ~rem_sub[DIC_DIV_W]};
          step_r <= step_r + 1'b1;
          if (div_done)
            div_st_r <= DIC_DIV_IDLE;
        end
      end
    end

    // new sample by mode
    always_comb
    begin
      samp = '0;
      samp_vld[i] = 1'b0;
      unique case (ctrl_r.scan)
        DIC_SCAN_NORM:
        begin
          samp_vld[i] = win_done;
          samp = 32'(edges_r) * 32'(DIC_NORM_SCALE); // R3 R6
        end
        DIC_SCAN_FAST:
        begin
          samp_vld[i] = win_done;
          samp = 32'(edges_r) * 32'(DIC_FAST_SCALE); // R4 R6
        end
        DIC_SCAN_SINGLE:
        begin
          samp_vld[i] = div_done || tmo;
          samp = tmo ? '0 : 32'({quo_r[DIC_DIV_W-2:0], ~rem_sub[DIC_DIV_W]}); // R5
        end
        default: samp_vld[i] = 1'b0;
      endcase
    end

    // moving average of the newest 1, 2, 4 or 8 samples
    always_comb
    begin
      sum = 35'(samp);
      for (int k = 0; k < 7; k++)
        if ((ctrl_r.avg == DIC_AVG_2 && k < 1) || (ctrl_r.avg == DIC_AVG_4 && k < 3)
            || (ctrl_r.avg == DIC_AVG_8))
          sum = sum + 35'(hist_r[k]); // R7
      unique case (ctrl_r.avg)
        DIC_AVG_2: avg_val = 32'(sum >> 1);
        DIC_AVG_4: avg_val = 32'(sum >> 2);
        DIC_AVG_8: avg_val = 32'(sum >> 3);
        default: avg_val = 32'(sum);
      endcase
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn || !freq_en_r[i])
      begin
        freq_r[i] <= '0; // R2
        samp_r <= '0;
        for (int k = 0; k < 8; k++)
          hist_r[k] <= '0;
      end
      else if (samp_vld[i])
      begin
        freq_r[i] <= avg_val; // R7
        samp_r <= samp;
        hist_r[0] <= samp;
        for (int k = 1; k < 8; k++)
          hist_r[k] <= hist_r[k-1];
      end
    end

    sequence s_norm_end;
      win_done && ctrl_r.scan == DIC_SCAN_NORM && freq_en_r[i];
    endsequence
    sequence s_fast_end;
      win_done && ctrl_r.scan == DIC_SCAN_FAST && freq_en_r[i];
    endsequence
    a_norm_sample: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      s_norm_end |=> samp_r == 32'($past(edges_r)) * 32'(DIC_NORM_SCALE))
      else $error("normal scan sample wrong");
    a_fast_sample: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      s_fast_end |=> samp_r == 32'($past(edges_r)) * 32'(DIC_FAST_SCALE))
      else $error("fast scan sample wrong");
    a_freq_off: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      !freq_en_r[i] |=> freq_r[i] == '0)
      else $error("disabled channel shows a frequency");
    a_count_preset: assert property (@(posedge aclk) disable iff (!aresetn) // R1
      cnt_clr_p |=> cnt_r[i] == $past(preset_r[i]))
      else $error("counter clear did not load preset");
    a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      (!cnt_en_r[i] && !cnt_clr_p) |=> $stable(cnt_r[i]))
      else $error("disabled counter moved");
  end

  // ==========================================================
  // checks
  a_clear_high: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    clr_hi_p |=> (lat_hi_r & ~$past(rise)) == '0)
    else $error("high latches not cleared");
  a_clear_low: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    clr_lo_p |=> (lat_lo_r & ~$past(fall)) == '0)
    else $error("low latches not cleared");
  a_latch_held: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    !clr_hi_p ##1 1'b1 |-> (lat_hi_r & $past(lat_hi_r)) == $past(lat_hi_r))
    else $error("high latch dropped without clear");
  a_latch_off: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    !ctrl_r.latch_en |=> (lat_lo_r & ~$past(lat_lo_r)) == '0)
    else $error("latch set while latching disabled");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq_r == $past(|(stat_r & mask_r)))
    else $error("interrupt does not follow masked status");
endmodule

/* File: include/dic_pkg.sv */
// constants, field layout and types of the digital input conditioning block
// assumes a single 250 MHz clock and an AXI4-Lite master with 32-bit data
package dic_pkg;
  // ==========================================================
  // timing
  localparam int DIC_CLK_PERIOD_NS = 4;
  localparam int DIC_MS_NS = 1_000_000;
  localparam int DIC_US_NS = 1_000;
  localparam int DIC_MS_CYC = DIC_MS_NS / DIC_CLK_PERIOD_NS;
  localparam int DIC_US_CYC = DIC_US_NS / DIC_CLK_PERIOD_NS;
  localparam int DIC_NORM_WIN_MS = 1000;
  localparam int DIC_FAST_WIN_MS = 100;
  // results are in units of 0.01 Hz
  localparam int DIC_NORM_SCALE = 100;
  localparam int DIC_FAST_SCALE = 1000;
  // 0.01 Hz period in microseconds, also the single-pulse dividend
  localparam int DIC_CENTI_NUM = 100_000_000;
  localparam int DIC_DIV_W = 27;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] DIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] DIC_CNT_EN_OFS = 8'h04;
  localparam logic [7:0] DIC_FREQ_EN_OFS = 8'h08;
  localparam logic [7:0] DIC_FILT_OFS = 8'h0C;
  localparam logic [7:0] DIC_DIR_OFS = 8'h10;
  localparam logic [7:0] DIC_INPUT_OFS = 8'h14;
  localparam logic [7:0] DIC_LAT_HI_OFS = 8'h18;
  localparam logic [7:0] DIC_LAT_LO_OFS = 8'h1C;
  localparam logic [7:0] DIC_STAT_OFS = 8'h20;
  localparam logic [7:0] DIC_MASK_OFS = 8'h24;
  localparam logic [7:0] DIC_PRESET_BASE = 8'h40;
  localparam logic [7:0] DIC_COUNT_BASE = 8'h60;
  localparam logic [7:0] DIC_FREQ_BASE = 8'h80;
  // ==========================================================
  // control register fields
  localparam int DIC_LATCH_BIT = 0;
  localparam int DIC_CLR_HI_BIT = 1;
  localparam int DIC_CLR_LO_BIT = 2;
  localparam int DIC_CNT_CLR_BIT = 3;
  localparam int DIC_SCAN_LSB = 4;
  localparam int DIC_AVG_LSB = 8;
  localparam logic [1:0] DIC_SCAN_NORM = 2'h0;
  localparam logic [1:0] DIC_SCAN_FAST = 2'h1;
  localparam logic [1:0] DIC_SCAN_SINGLE = 2'h2;
  localparam logic [3:0] DIC_AVG_1 = 4'h1;
  localparam logic [3:0] DIC_AVG_2 = 4'h2;
  localparam logic [3:0] DIC_AVG_4 = 4'h4;
  localparam logic [3:0] DIC_AVG_8 = 4'h8;
  localparam logic [1:0] DIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DIC_RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef struct packed {
    logic [3:0] avg;
    logic [1:0] scan;
    logic latch_en;
  } dic_ctrl_t;
  typedef enum logic [1:0] {
    DIC_DIV_IDLE = 2'b01,
    DIC_DIV_RUN = 2'b10
  } dic_div_st_t;
endpackage

/* File: verification/dic_field.sv */
// field side model: square-wave pulse trains on the channel inputs
// assumes the bench changes run and half just after a rising edge
`timescale 1ns/1ps
module dic_field
#(
  parameter int NCH = 4
)
(
  input wire logic aclk,
  input wire logic [NCH-1:0] run,
  input wire logic [15:0] half,
  output logic [NCH-1:0] din = '0
);
  logic [15:0] cnt = '0;
  // ========================================
  // toggle every half period; a stopped channel drops low on the next cycle that is not a toggle
  always_ff @(posedge aclk)
  begin
    cnt <= (cnt >= half - 16'h1) ? 16'h0 : cnt + 16'h1;
    din <= (cnt >= half - 16'h1) ? (din ^ run) : (din & run);
  end
endmodule

/* File: verification/digital_input_conditioning_tb.sv */
// bench for dic_top: reset table, then filter, latch, counter, irq and frequency cases
// assumes dic_field drives din; the tasks run one bus transfer at a time
`timescale 1ns/1ps
module digital_input_conditioning_tb
  import dic_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} dic_row_t;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, p0 = 0, bready = 0, rready = 0;
  logic [31:0] wdata = 0, rdv, rdata;
  logic [1:0] rrp, brp, bresp, rresp;
  logic [3:0] run = 0, wstrb = 0, din, dir;
  logic [15:0] half = 16'h4;
  logic awready, wready, bvalid, arready, rvalid, irq;
  int n_fail = 0, n_tests = 0, cyc = 0, nrise = 0;
  dic_row_t rows [7] = '{'{DIC_CTRL_OFS, 32'h100, 2'h0}, '{DIC_DIR_OFS, 32'hF, 2'h0},
    '{DIC_FILT_OFS, 32'h0, 2'h0}, '{DIC_CNT_EN_OFS, 32'h0, 2'h0},
    '{DIC_LAT_HI_OFS, 32'h0, 2'h0}, '{DIC_MASK_OFS, 32'h0, 2'h0}, '{8'hFC, 32'h0, 2'h2}};
  dic_top #(.NCH(4), .MS_CYCLES(10), .FW(16)) u_dic_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .din(din), .dio_dir_r(dir), .irq_r(irq));
  dic_field #(.NCH(4)) u_dic_field (.aclk(aclk), .run(run), .half(half), .din(din));
  initial forever #2 aclk = ~aclk;
  // ========================================
  // timeout and rising-edge tally of channel 0
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    p0 <= din[0];
    if (din[0] & ~p0)
      nrise <= nrise + 1;
    if (cyc == 80000)
    begin
      n_fail++;
      results();
    end
  end
  // ========================================
  // bus tasks; valid drops only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    brp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rdv = rdata;
    rrp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // range compare; lo equal to hi is an exact match
  task automatic chk(input string n, input logic [31:0] lo, hi, g);
    n_tests++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, lo, g);
    end
  endtask
  task automatic pulse(input logic [3:0] ch, input int n);
    run <= ch;
    repeat (n) @(posedge aclk);
    run <= 4'h0;
    repeat (10) @(posedge aclk);
  endtask
  task automatic results();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ========================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("resp", rows[i].r, rows[i].r, rrp);
      if (rows[i].r == 2'h0)
        chk("data", rows[i].d, rows[i].d, rdv);
    end
    wr(8'hFC, 32'h0);
    chk("bresp", 32'h2, 32'h2, brp);
    // short noise must not pass a 2 ms filter
    wr(DIC_FILT_OFS, 32'h2);
    wr(DIC_CTRL_OFS, 32'h101);
    pulse(4'h1, 60);
    rd(DIC_LAT_HI_OFS);
    chk("filt", 32'h0, 32'h0, rdv);
    wr(DIC_FILT_OFS, 32'h0);
    wr(DIC_CTRL_OFS, 32'h100);
    pulse(4'h1, 40);
    rd(DIC_LAT_HI_OFS);
    chk("lat_off", 32'h0, 32'h0, rdv);
    wr(DIC_CTRL_OFS, 32'h101);
    pulse(4'h1, 40);
    rd(DIC_LAT_LO_OFS);
    chk("lat_lo", 32'h1, 32'h1, rdv);
    wr(DIC_CTRL_OFS, 32'h103);
    rd(DIC_LAT_HI_OFS);
    chk("clr_hi", 32'h0, 32'h0, rdv);
    rd(DIC_LAT_LO_OFS);
    chk("keep_lo", 32'h1, 32'h1, rdv);
    wr(DIC_CTRL_OFS, 32'h105);
    rd(DIC_LAT_LO_OFS);
    chk("clr_lo", 32'h0, 32'h0, rdv);
    // counters start from presets; channel 1 not enabled
    wr(DIC_PRESET_BASE, 32'h64);
    wr(DIC_PRESET_BASE + 8'h4, 32'h7);
    wr(DIC_CNT_EN_OFS, 32'h1);
    wr(DIC_CTRL_OFS, 32'h109);
    nrise = 0;
    pulse(4'h3, 80);
    rd(DIC_COUNT_BASE);
    chk("count0", 32'(100 + nrise), 32'(100 + nrise), rdv);
    rd(DIC_COUNT_BASE + 8'h4);
    chk("count1", 32'h7, 32'h7, rdv);
    // interrupt cleared, raised, masked
    wr(DIC_MASK_OFS, 32'h1);
    wr(DIC_STAT_OFS, 32'hFFFF_FFFF);
    repeat (2) @(posedge aclk);
    chk("irq_idle", 32'h0, 32'h0, irq);
    pulse(4'h1, 20);
    chk("irq_set", 32'h1, 32'h1, irq);
    wr(DIC_MASK_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_mask", 32'h0, 32'h0, irq);
    wr(DIC_DIR_OFS, 32'h5);
    chk("dir", 32'h5, 32'h5, dir);
    // low byte only: clear-high runs, averaging field untouched
    wr(DIC_CTRL_OFS, 32'h0000_0403, 4'h1);
    rd(DIC_CTRL_OFS);
    chk("strb", 32'h101, 32'h101, rdv);
    // frequency: 100-cycle period is 100 Hz at the shortened ms
    half <= 16'h32;
    wr(DIC_FREQ_EN_OFS, 32'h1);
    run <= 4'h3;
    repeat (25000) @(posedge aclk);
    rd(DIC_FREQ_BASE);
    chk("f_norm", 32'h26AC, 32'h2774, rdv);
    rd(DIC_FREQ_BASE + 8'h4);
    chk("f_off", 32'h0, 32'h0, rdv);
    rd(DIC_LAT_HI_OFS);
    chk("dir_in", 32'h1, 32'h1, rdv);
    wr(DIC_CTRL_OFS, 32'h811);
    repeat (10000) @(posedge aclk);
    rd(DIC_FREQ_BASE);
    chk("f_fast", 32'h2328, 32'h2AF8, rdv);
    half <= 16'h4E2;
    wr(DIC_CTRL_OFS, 32'h221);
    repeat (20000) @(posedge aclk);
    rd(DIC_FREQ_BASE);
    chk("f_single", 32'h0089_5440, 32'h009A_1D20, rdv);
    results();
  end
endmodule
